// ---- src/ebpc_params.svh ----
`ifndef EBPC_PARAMS_SVH
`define EBPC_PARAMS_SVH

// Bank numbers whose select pins this block drives.
`define EBPC_BANK_SRAM0      3'h0
`define EBPC_BANK_SRAM1      3'h1
`define EBPC_BANK_SHARED4    3'h4

// Field widths.
`define EBPC_BANK_W          3
`define EBPC_LANE_W          4
`define EBPC_WAIT_W          4
`define EBPC_DMA_CH          4

// Idle level of the lane strobes, and wait count values.
`define EBPC_LANES_IDLE_N    4'hf
`define EBPC_WAIT_ZERO       4'h0
`define EBPC_WAIT_ONE        4'h1

// Edges after reset release before the second boot width sample is taken.
// It covers the three stage input path so the sample sees the released level.
`define EBPC_BOOT_POST_DELAY 3'h4
`define EBPC_POST_CNT_W      3

// Idle levels at the pin filter inputs: bit 0 boot width, bit 1 fault, bit 2 irq.
`define EBPC_PIN_IDLE        3'h6
`define EBPC_PIN_BOOT        0
`define EBPC_PIN_FAULT       1
`define EBPC_PIN_IRQ         2

`endif

// ---- src/ebpc_pkg.sv ----
`include "ebpc_params.svh"

package ebpc_pkg;

    typedef enum logic [2:0] {
        ST_IDLE   = 3'h0,
        ST_ROW    = 3'h1,
        ST_ACCESS = 3'h3,
        ST_XFER   = 3'h2
    } ebpc_state_e;

    typedef enum logic [1:0] {
        BOOT_8  = 2'h0,
        BOOT_16 = 2'h1,
        BOOT_32 = 2'h2
    } ebpc_boot_e;

    typedef struct packed {
        logic [`EBPC_BANK_W-1:0] bank;
        logic [`EBPC_LANE_W-1:0] lanes;
        logic [`EBPC_WAIT_W-1:0] waits;
    } ebpc_req_s;

    typedef struct packed {
        logic                     active;
        logic                     full_rate;
        logic                     step;
        logic [`EBPC_DMA_CH-1:0]  ack;
    } ebpc_dma_s;

endpackage : ebpc_pkg

// ---- src/ebpc_pin_sync.sv ----
// Three stage input path with a filtered output: the output only follows
// once the second and third stages agree, so a single-cycle glitch that
// reaches only one of them is discarded.
module ebpc_pin_sync #(
    parameter int WIDTH = 3
) (
    // Clock
    input  wire logic             clk,
    // Asynchronous pin levels
    input  wire logic [WIDTH-1:0] pin,
    // Filtered levels
    output logic      [WIDTH-1:0] level
);

    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
    logic [WIDTH-1:0] stage3;
    logic [WIDTH-1:0] next_level;

    // The path has no reset so that the boot width pin can be sampled while
    // reset is held; it settles within four edges of a running clock.
    always_comb begin
        for (int i = 0; i < WIDTH; i++) begin
            next_level[i] = (stage2[i] == stage3[i]) ? stage2[i] : level[i];
        end
    end

    always_ff @(posedge clk) begin
        stage1 <= pin;
        stage2 <= stage1;
        stage3 <= stage2;
        level  <= next_level;
    end

endmodule : ebpc_pin_sync

// ---- src/ebpc_top.sv ----
`include "ebpc_params.svh"

module ebpc_top
    import ebpc_pkg::*;
(
    // Clock and reset
    input  wire logic                    MCLK_IN,
    input  wire logic                    RST_IN,
    // Access request from the bus unit
    input  wire logic                    REQ_VALID_IN,
    input  wire ebpc_req_s               REQ_IN,
    output logic                         REQ_READY_OUT,
    output logic                         XFER_DONE_OUT,
    output logic                         XFER_FAULT_OUT,
    // Bank configuration
    input  wire logic [1:0]              BANK_SRAM_CFG_IN,
    input  wire logic                    BANK4_IS_DRAM_IN,
    // Bus ownership and DMA
    input  wire logic                    HOLD_GRANT_ACK_IN,
    input  wire logic                    BUS_OP_PENDING_IN,
    input  wire ebpc_dma_s               DMA_IN,
    // Pins from the board
    input  wire logic                    BOOT_ROM_WIDTH_SELECT_IN,
    input  wire logic                    BUS_FAULT_N_IN,
    input  wire logic                    CRITICAL_IRQ_N_IN,
    // Memory control pins
    output logic                         DRAM_ADDR_MUX_SELECT_OUT,
    output logic [`EBPC_LANE_W-1:0]      COLUMN_STROBE_LANE_N_OUT,
    output logic                         SRAM_SELECT_BANK0_N_OUT,
    output logic                         SRAM_SELECT_BANK1_N_OUT,
    output logic                         SELECT_OR_ROW_STROBE_BANK4_N_OUT,
    // Shared bus request and DMA strobe pin, DMA acknowledge pins
    output logic                         BUS_REGAIN_DMA_STROBE_OUT,
    output logic [`EBPC_DMA_CH-1:0]      DMA_ACKNOWLEDGE_LINES_N_OUT,
    // Results for the core
    output ebpc_boot_e                   BOOT_WIDTH_OUT,
    output logic                         BOOT_VALID_OUT,
    output logic                         CRIT_IRQ_OUT
);

    function automatic logic select_hit(input logic [`EBPC_BANK_W-1:0] bank,
                                        input logic [`EBPC_BANK_W-1:0] target,
                                        input logic                    enabled,
                                        input ebpc_state_e             st);
        select_hit = (bank == target) && enabled && (st != ST_IDLE);
    endfunction : select_hit

    function automatic logic is_dram(input logic [`EBPC_BANK_W-1:0] bank,
                                     input logic                    cfg);
        is_dram = (bank == `EBPC_BANK_SHARED4) && cfg;
    endfunction : is_dram

    // Filtered pin levels.
    logic [2:0] pin_level;

    ebpc_pin_sync #(
        .WIDTH (3)
    ) u_pin_sync (
        .clk   (MCLK_IN),
        .pin   ({CRITICAL_IRQ_N_IN, BUS_FAULT_N_IN, BOOT_ROM_WIDTH_SELECT_IN}),
        .level (pin_level)
    );

    logic boot_level;
    logic fault_n_level;
    logic irq_n_level;
    assign boot_level    = pin_level[`EBPC_PIN_BOOT];
    assign fault_n_level = pin_level[`EBPC_PIN_FAULT];
    assign irq_n_level   = pin_level[`EBPC_PIN_IRQ];

    // Access sequencer state.
    ebpc_state_e             state;
    ebpc_state_e             next_state;
    ebpc_req_s               req;
    ebpc_req_s               next_req;
    logic [`EBPC_WAIT_W-1:0] cnt;
    logic [`EBPC_WAIT_W-1:0] next_cnt;
    logic                    fault;
    logic                    next_fault;
    logic                    fault_now;
    logic                    next_ready;
    logic                    next_done;
    logic                    next_fault_out;
    logic                    next_mux;
    logic [`EBPC_LANE_W-1:0] next_cas_n;
    logic                    next_cs0_n;
    logic                    next_cs1_n;
    logic                    next_cs4_n;
    logic                    dram_next;
    logic                    col_phase;

    always_comb begin
        next_state     = state;
        next_req       = req;
        next_cnt       = cnt;
        next_fault     = fault;
        next_done      = 1'b0;
        next_fault_out = 1'b0;
        // The fault pin counts only in the last wait or the transfer cycle.
        fault_now = !fault_n_level &&
                    (((state == ST_ACCESS) && (cnt == `EBPC_WAIT_ONE)) ||
                     (state == ST_XFER));
        case (state)
            ST_IDLE: begin
                if (REQ_VALID_IN) begin
                    next_req   = REQ_IN;
                    next_cnt   = REQ_IN.waits;
                    next_fault = 1'b0;
                    if (is_dram(REQ_IN.bank, BANK4_IS_DRAM_IN)) begin
                        next_state = ST_ROW;
                    end else if (REQ_IN.waits == `EBPC_WAIT_ZERO) begin
                        next_state = ST_XFER;
                    end else begin
                        next_state = ST_ACCESS;
                    end
                end
            end
            ST_ROW: begin
                next_state = (cnt == `EBPC_WAIT_ZERO) ? ST_XFER : ST_ACCESS;
            end
            ST_ACCESS: begin
                next_fault = fault | fault_now;
                next_cnt   = cnt - `EBPC_WAIT_ONE;
                if (cnt == `EBPC_WAIT_ONE) begin
                    next_state = ST_XFER;
                end
            end
            ST_XFER: begin
                next_done      = 1'b1;
                next_fault_out = fault | fault_now;
                next_state     = ST_IDLE;
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
        if (RST_IN) begin
            next_state = ST_IDLE;
            next_fault = 1'b0;
            next_cnt   = `EBPC_WAIT_ZERO;
            next_done  = 1'b0;
            next_fault_out = 1'b0;
        end

        // Pin levels follow the state being entered, so every pin is a flop.
        dram_next  = is_dram(next_req.bank, BANK4_IS_DRAM_IN);
        col_phase  = (next_state == ST_ACCESS) || (next_state == ST_XFER);
        next_mux   = dram_next && col_phase;
        next_cas_n = (dram_next && col_phase) ? ~next_req.lanes
                                              : `EBPC_LANES_IDLE_N;
        next_cs0_n = !select_hit(next_req.bank, `EBPC_BANK_SRAM0,
                                 BANK_SRAM_CFG_IN[0], next_state);
        next_cs1_n = !select_hit(next_req.bank, `EBPC_BANK_SRAM1,
                                 BANK_SRAM_CFG_IN[1], next_state);
        // Row strobe for DRAM from the row cycle on, or a plain select for SRAM.
        next_cs4_n = !select_hit(next_req.bank, `EBPC_BANK_SHARED4,
                                 1'b1, next_state);
        next_ready = (next_state == ST_IDLE);
    end

    always_ff @(posedge MCLK_IN) begin
        state                            <= next_state;
        req                              <= next_req;
        cnt                              <= next_cnt;
        fault                            <= next_fault;
        REQ_READY_OUT                    <= next_ready;
        XFER_DONE_OUT                    <= next_done;
        XFER_FAULT_OUT                   <= next_fault_out;
        DRAM_ADDR_MUX_SELECT_OUT         <= next_mux;
        COLUMN_STROBE_LANE_N_OUT         <= next_cas_n;
        SRAM_SELECT_BANK0_N_OUT          <= next_cs0_n;
        SRAM_SELECT_BANK1_N_OUT          <= next_cs1_n;
        SELECT_OR_ROW_STROBE_BANK4_N_OUT <= next_cs4_n;
    end

    // Shared pin and DMA acknowledge.
    logic                    next_shared;
    logic [`EBPC_DMA_CH-1:0] next_dack_n;
    logic                    dma_strobe;

    always_comb begin
        // Without an acknowledge the strobe carries no meaning, so it is held off.
        dma_strobe = DMA_IN.active && (|DMA_IN.ack) &&
                     (DMA_IN.full_rate || DMA_IN.step);
        if (HOLD_GRANT_ACK_IN) begin
            next_shared = BUS_OP_PENDING_IN;
        end else begin
            next_shared = dma_strobe;
        end
        next_dack_n = ~DMA_IN.ack;
        if (RST_IN) begin
            next_shared = 1'b0;
            next_dack_n = {`EBPC_DMA_CH{1'b1}};
        end
    end

    always_ff @(posedge MCLK_IN) begin
        BUS_REGAIN_DMA_STROBE_OUT   <= next_shared;
        DMA_ACKNOWLEDGE_LINES_N_OUT <= next_dack_n;
    end

    // Boot width capture.
    logic                        boot_in_reset;
    logic                        next_boot_in_reset;
    logic [`EBPC_POST_CNT_W-1:0] post_cnt;
    logic [`EBPC_POST_CNT_W-1:0] next_post_cnt;
    ebpc_boot_e                  next_boot_width;
    logic                        next_boot_valid;

    always_comb begin
        next_boot_in_reset = boot_in_reset;
        next_post_cnt      = post_cnt;
        next_boot_width    = BOOT_WIDTH_OUT;
        next_boot_valid    = BOOT_VALID_OUT;
        if (RST_IN) begin
            next_boot_in_reset = boot_level;
            next_post_cnt      = '0;
            next_boot_width    = BOOT_8;
            next_boot_valid    = 1'b0;
        end else if (!BOOT_VALID_OUT) begin
            if (post_cnt == `EBPC_BOOT_POST_DELAY) begin
                // A pin that follows reset differs between the two samples.
                next_boot_valid = 1'b1;
                if (boot_in_reset != boot_level) begin
                    next_boot_width = BOOT_16;
                end else if (boot_level) begin
                    next_boot_width = BOOT_32;
                end else begin
                    next_boot_width = BOOT_8;
                end
            end else begin
                next_post_cnt = post_cnt + 3'h1;
            end
        end
    end

    always_ff @(posedge MCLK_IN) begin
        boot_in_reset  <= next_boot_in_reset;
        post_cnt       <= next_post_cnt;
        BOOT_WIDTH_OUT <= next_boot_width;
        BOOT_VALID_OUT <= next_boot_valid;
    end

    // Critical interrupt: a filtered low arms, the following filtered high fires.
    logic seen_low;
    logic next_seen_low;
    logic next_irq;

    always_comb begin
        next_seen_low = seen_low;
        next_irq      = 1'b0;
        if (!irq_n_level) begin
            next_seen_low = 1'b1;
        end else if (seen_low) begin
            next_irq      = 1'b1;
            next_seen_low = 1'b0;
        end
        if (RST_IN) begin
            next_seen_low = 1'b0;
            next_irq      = 1'b0;
        end
    end

    always_ff @(posedge MCLK_IN) begin
        seen_low     <= next_seen_low;
        CRIT_IRQ_OUT <= next_irq;
    end

endmodule : ebpc_top

// ---- verif/ebpc_board_model.sv ----
// Board side: an outside device that flags failed transfers and a source of critical interrupts.
module ebpc_board_model (
    // Clock
    input  wire logic clk_in,
    // Commands from the bench
    input  wire logic fault_in,
    input  wire logic irq_in,
    // Board pins
    output logic      bus_fault_n_out,
    output logic      critical_irq_n_out
);
    timeunit 1ns;
    timeprecision 100ps;

    logic [3:0] irq_cnt = 4'h0;

    initial begin
        bus_fault_n_out    = 1'b1;
        critical_irq_n_out = 1'b1;
    end

    always @(posedge clk_in) begin
        bus_fault_n_out <= !fault_in;
    end

    // Low for three cycles, then high: longer than the minimum both ways, so a slow filter still sees it.
    always @(posedge clk_in) begin
        if (irq_in) begin
            irq_cnt <= 4'h6;
        end else if (irq_cnt != 4'h0) begin
            irq_cnt <= irq_cnt - 4'h1;
        end
        critical_irq_n_out <= !(irq_cnt > 4'h3);
    end
endmodule : ebpc_board_model

// ---- verif/ebpc_top_chk.sv ----
`include "ebpc_params.svh"

module ebpc_top_chk
    import ebpc_pkg::*;
(
    // Clock and reset
    input wire logic         MCLK_IN,
    input wire logic         RST_IN,
    // Access side and bank setup
    input wire logic         REQ_VALID_IN,
    input wire ebpc_req_s    REQ_IN,
    input wire logic         REQ_READY_OUT,
    input wire logic         XFER_DONE_OUT,
    input wire logic         XFER_FAULT_OUT,
    input wire logic [1:0]   BANK_SRAM_CFG_IN,
    input wire logic         BANK4_IS_DRAM_IN,
    // Ownership, DMA and interrupt
    input wire logic         HOLD_GRANT_ACK_IN,
    input wire logic         BUS_OP_PENDING_IN,
    input wire ebpc_dma_s    DMA_IN,
    input wire logic         CRITICAL_IRQ_N_IN,
    // Pins and results
    input wire logic         DRAM_ADDR_MUX_SELECT_OUT,
    input wire logic [3:0]   COLUMN_STROBE_LANE_N_OUT,
    input wire logic         SRAM_SELECT_BANK0_N_OUT,
    input wire logic         SRAM_SELECT_BANK1_N_OUT,
    input wire logic         SELECT_OR_ROW_STROBE_BANK4_N_OUT,
    input wire logic         BUS_REGAIN_DMA_STROBE_OUT,
    input wire logic [3:0]   DMA_ACKNOWLEDGE_LINES_N_OUT,
    input wire ebpc_boot_e   BOOT_WIDTH_OUT,
    input wire logic         BOOT_VALID_OUT,
    input wire logic         CRIT_IRQ_OUT
);
    logic       take, t0, t1, t4, dma_go;
    logic [3:0] low_age;

    assign take   = REQ_VALID_IN && REQ_READY_OUT;
    assign t0     = take && REQ_IN.bank == 3'h0;
    assign t1     = take && REQ_IN.bank == 3'h1;
    assign t4     = take && REQ_IN.bank == 3'h4;
    assign dma_go = DMA_IN.active && (|DMA_IN.ack) && (DMA_IN.full_rate || DMA_IN.step);

    // Cycles since the interrupt pin was last seen low; saturates so it never wraps.
    always_ff @(posedge MCLK_IN) begin
        if (RST_IN || !CRITICAL_IRQ_N_IN) begin
            low_age <= 4'h0;
        end else if (low_age != 4'hf) begin
            low_age <= low_age + 4'h1;
        end
    end

    default clocking cb @(posedge MCLK_IN); endclocking
    default disable iff (RST_IN);

    sequence s_dram_take;
        t4 && BANK4_IS_DRAM_IN && REQ_IN.waits != 4'h0;
    endsequence
    sequence s_row;
        !SELECT_OR_ROW_STROBE_BANK4_N_OUT && !DRAM_ADDR_MUX_SELECT_OUT
            && COLUMN_STROBE_LANE_N_OUT == 4'hf;
    endsequence
    sequence s_col;
        DRAM_ADDR_MUX_SELECT_OUT && COLUMN_STROBE_LANE_N_OUT == ~$past(REQ_IN.lanes, 2);
    endsequence

    a_dram_row_col: assert property (
        s_dram_take |=> s_row ##1 s_col)
        else $error("Row phase then column phase not shown");
    a_sram_bank0: assert property (
        t0 && BANK_SRAM_CFG_IN[0] |=> !SRAM_SELECT_BANK0_N_OUT)
        else $error("Bank 0 select not driven");
    a_bank1_off: assert property (
        t1 && !BANK_SRAM_CFG_IN[1] |=> SRAM_SELECT_BANK1_N_OUT)
        else $error("Bank 1 select driven while not set up");
    a_bank4_sram: assert property (
        t4 && !BANK4_IS_DRAM_IN |=> !SELECT_OR_ROW_STROBE_BANK4_N_OUT
            && COLUMN_STROBE_LANE_N_OUT == 4'hf)
        else $error("Bank 4 select wrong for static memory");
    a_regain_req: assert property (
        !$past(RST_IN) && $past(HOLD_GRANT_ACK_IN)
            |-> BUS_REGAIN_DMA_STROBE_OUT == $past(BUS_OP_PENDING_IN))
        else $error("Bus request does not follow pending operation");
    a_dma_strobe: assert property (
        !$past(RST_IN) && !$past(HOLD_GRANT_ACK_IN)
            |-> BUS_REGAIN_DMA_STROBE_OUT == $past(dma_go))
        else $error("DMA strobe wrong");
    a_dma_ack: assert property (
        !$past(RST_IN) |-> DMA_ACKNOWLEDGE_LINES_N_OUT == ~$past(DMA_IN.ack))
        else $error("DMA acknowledge lines wrong");
    a_fault_done: assert property (
        XFER_FAULT_OUT |-> XFER_DONE_OUT ##1 !XFER_DONE_OUT)
        else $error("Fault flag outside a one cycle done");
    a_boot_stable: assert property (
        BOOT_VALID_OUT |=> BOOT_VALID_OUT && $stable(BOOT_WIDTH_OUT))
        else $error("Boot width changed after capture");
    a_irq_pulse: assert property (
        CRIT_IRQ_OUT |-> low_age >= 4'h2 && low_age <= 4'hb ##1 !CRIT_IRQ_OUT)
        else $error("Interrupt pulse without a low then high");
endmodule : ebpc_top_chk

bind ebpc_top ebpc_top_chk chk_u (
    .MCLK_IN, .RST_IN, .REQ_VALID_IN, .REQ_IN, .REQ_READY_OUT, .XFER_DONE_OUT,
    .XFER_FAULT_OUT, .BANK_SRAM_CFG_IN, .BANK4_IS_DRAM_IN, .HOLD_GRANT_ACK_IN,
    .BUS_OP_PENDING_IN, .DMA_IN, .CRITICAL_IRQ_N_IN, .DRAM_ADDR_MUX_SELECT_OUT,
    .COLUMN_STROBE_LANE_N_OUT, .SRAM_SELECT_BANK0_N_OUT, .SRAM_SELECT_BANK1_N_OUT,
    .SELECT_OR_ROW_STROBE_BANK4_N_OUT, .BUS_REGAIN_DMA_STROBE_OUT,
    .DMA_ACKNOWLEDGE_LINES_N_OUT, .BOOT_WIDTH_OUT, .BOOT_VALID_OUT, .CRIT_IRQ_OUT
);

// ---- verif/ebpc_top_tb.sv ----
`include "ebpc_params.svh"

module ebpc_top_tb
    import ebpc_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    // Rows: hold, pending, active, full rate, step, ack 0, expected shared pin.
    localparam logic [6:0] ROWS [9] = '{7'h61, 7'h40, 7'h17, 7'h12, 7'h1b, 7'h1b, 7'h18,
                                       7'h5a, 7'h00};

    logic       clk, rst, req_valid, b4_dram, hold, pend, fault_on, irq_go;
    logic [1:0] cfg, boot_mode;
    logic       boot_pin, fault_n, irq_n;
    ebpc_req_s  req;
    ebpc_dma_s  dma;
    logic       ready, done, fault, mux, cs0_n, cs1_n, cs4_n, shared, boot_valid, irq;
    logic [3:0] lanes_n, dack_n;
    ebpc_boot_e boot_w;
    int         n_fail, comparisons, cycles;

    // The board ties the pin low, high, or to reset for the middle width.
    assign boot_pin = boot_mode[1] ? rst : boot_mode[0];

    ebpc_top dut_u (
        .MCLK_IN(clk), .RST_IN(rst), .REQ_VALID_IN(req_valid), .REQ_IN(req),
        .REQ_READY_OUT(ready), .XFER_DONE_OUT(done), .XFER_FAULT_OUT(fault),
        .BANK_SRAM_CFG_IN(cfg), .BANK4_IS_DRAM_IN(b4_dram), .HOLD_GRANT_ACK_IN(hold),
        .BUS_OP_PENDING_IN(pend), .DMA_IN(dma), .BOOT_ROM_WIDTH_SELECT_IN(boot_pin),
        .BUS_FAULT_N_IN(fault_n), .CRITICAL_IRQ_N_IN(irq_n), .DRAM_ADDR_MUX_SELECT_OUT(mux),
        .COLUMN_STROBE_LANE_N_OUT(lanes_n), .SRAM_SELECT_BANK0_N_OUT(cs0_n),
        .SRAM_SELECT_BANK1_N_OUT(cs1_n), .SELECT_OR_ROW_STROBE_BANK4_N_OUT(cs4_n),
        .BUS_REGAIN_DMA_STROBE_OUT(shared), .DMA_ACKNOWLEDGE_LINES_N_OUT(dack_n),
        .BOOT_WIDTH_OUT(boot_w), .BOOT_VALID_OUT(boot_valid), .CRIT_IRQ_OUT(irq));

    ebpc_board_model board_u (.clk_in(clk), .fault_in(fault_on), .irq_in(irq_go),
                              .bus_fault_n_out(fault_n), .critical_irq_n_out(irq_n));

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            n_fail++;
            results();
        end
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error at %0t ns: seen %h, expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic results();
        $display("Comparisons %0d, mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : results

    // Reset is held seven edges: the pin path has no reset and must settle first.
    task automatic boot_case(input logic [1:0] mode, input ebpc_boot_e exp);
        @(posedge clk);
        boot_mode <= mode;
        rst       <= 1'b1;
        repeat (6) @(posedge clk);
        #1;
        check({ready, done, fault, cs0_n, cs1_n, cs4_n, shared, irq}, 8'h9c);
        check({lanes_n, dack_n}, 8'hff);
        @(posedge clk);
        rst <= 1'b0;
        repeat (10) @(posedge clk);
        #1;
        check(boot_valid, 1'b1);
        check(boot_w, exp);
    endtask : boot_case

    task automatic access(input logic [2:0] bank, input logic [3:0] ln, input logic [3:0] w,
                          input logic fault_exp);
        int         n;
        logic [2:0] sel;
        @(posedge clk);
        req_valid <= 1'b1;
        req       <= {bank, ln, w};
        @(posedge clk);
        req_valid <= 1'b0;
        n   = 0;
        sel = 3'h7;
        #1;
        while (done !== 1'b1 && n < 40) begin
            sel = sel & {cs0_n, cs1_n, cs4_n};
            n++;
            @(posedge clk);
            #1;
        end
        check(8'(n), 8'(w + ((bank == 3'h4 && b4_dram) ? 2 : 1)));
        check(fault, fault_exp);
        check(sel, {!(bank == 3'h0 && cfg[0]), !(bank == 3'h1 && cfg[1]), bank != 3'h4});
    endtask : access

    // A held fault is flagged; one released before the sampling window is not.
    task automatic fault_case();
        @(posedge clk);
        fault_on <= 1'b1;
        repeat (6) @(posedge clk);
        access(3'h4, 4'hf, 4'h2, 1'b1);
        @(posedge clk);
        fault_on <= 1'b0;
        repeat (8) @(posedge clk);
        fault_on <= 1'b1;
        repeat (8) @(posedge clk);
        fault_on <= 1'b0;
        access(3'h4, 4'h3, 4'h8, 1'b0);
    endtask : fault_case

    task automatic shared_case();
        for (int i = 0; i < 10; i++) begin
            @(posedge clk);
            if (i < 9) begin
                hold <= ROWS[i][6];
                pend <= ROWS[i][5];
                dma  <= {ROWS[i][4:2], 3'h0, ROWS[i][1]};
            end
            #1;
            if (i > 0) begin
                check(shared, ROWS[i-1][0]);
                check(dack_n, {3'h7, !ROWS[i-1][1]});
            end
        end
    endtask : shared_case

    task automatic irq_case();
        int k;
        @(posedge clk);
        irq_go <= 1'b1;
        @(posedge clk);
        irq_go <= 1'b0;
        k = 0;
        repeat (20) begin
            @(posedge clk);
            #1;
            k += int'(irq === 1'b1);
        end
        check(8'(k), 8'h01);
    endtask : irq_case

    initial begin
        {rst, req_valid, b4_dram, hold, pend, fault_on, irq_go} = 7'h50;
        cfg         = 2'h1;
        boot_mode   = 2'h0;
        req         = '0;
        dma         = '0;
        n_fail      = 0;
        comparisons = 0;
        cycles      = 0;
        boot_case(2'h0, BOOT_8);
        boot_case(2'h1, BOOT_32);
        boot_case(2'h2, BOOT_16);
        access(3'h4, 4'h5, 4'h2, 1'b0);
        access(3'h0, 4'hf, 4'h0, 1'b0);
        access(3'h1, 4'h3, 4'h1, 1'b0);
        fault_case();
        @(posedge clk);
        cfg     <= 2'h2;
        b4_dram <= 1'b0;
        access(3'h1, 4'hc, 4'h0, 1'b0);
        access(3'h4, 4'h6, 4'h1, 1'b0);
        access(3'h2, 4'h1, 4'h0, 1'b0);
        shared_case();
        irq_case();
        results();
    end
endmodule : ebpc_top_tb
